/* File: rtl/fault_escalation.sv */
// fault escalation, shutdown and error code delivery
//
// The register offsets and the strobed register port were decided locally.
`timescale 1ns/10ps
`include "fault_escalation_regs.svh"
module fault_escalation
   import fault_escalation_pkg::*;
(
   input  wire logic        clock,
   input  wire logic        srst,
   input  wire logic [7:0]  regAddr,
   input  wire logic [31:0] regWdata,
   input  wire logic        regWrite,
   input  wire logic        regRead,
   output logic [31:0]      regRdata,
   input  wire logic        excValid,
   input  wire logic [7:0]  excVector,
   input  wire logic [31:0] excErrCode,
   input  wire logic        excHasErr,
   input  wire logic        chkValid,
   input  wire src_t        chkSource,
   input  wire cond_t       chkCond,
   input  wire seg_t        chkSeg,
   input  wire logic [15:0] tssSel,
   input  wire logic [15:0] ldtSel,
   input  wire logic [15:0] csSel,
   input  wire logic [15:0] dataSel,
   input  wire logic [15:0] gateSel,
   input  wire logic [15:0] ssSel,
   input  wire logic        nmiPin,
   input  wire logic        initPin,
   input  wire logic        handlerStart,
   input  wire logic        iretDone,
   output logic             dispatchValid,
   output logic [7:0]       dispatchVector,
   output logic [31:0]      dispatchErrCode,
   output logic             dispatchHasErr,
   output ipsel_t           dispatchIpSel,
   output logic             shutdown,
   output logic             restart
);

   // ----------------------------------------
   // class decode
   // ----------------------------------------
   function automatic class_t classOf(input logic [7:0] vec);
      case (vec)
         `VEC_DE, `VEC_TS, `VEC_NP, `VEC_SS, `VEC_GP:
            classOf = CL_CONTRIB;
         `VEC_PF: classOf = CL_PAGE;
         `VEC_DF: classOf = CL_DOUBLE;
         default: classOf = CL_BENIGN;
      endcase
   endfunction

   state_t      state;
   state_t      next_state;
   class_t      dlvClass;
   logic        longMode;
   logic        nmiMeta;
   logic        nmiSync;
   logic        nmiLast;
   logic        initMeta;
   logic        initSync;
   logic        initLast;
   logic        nmiEdge;
   logic        initEdge;
   logic        nmiPending;
   logic        inNmi;
   logic        nmiLocked;
   logic        chkHit;
   logic [7:0]  chkVector;
   logic [31:0] chkErr;
   ipsel_t      chkIp;
   logic        evValid;
   logic [7:0]  evVector;
   logic [31:0] evErr;
   logic        evHasErr;
   ipsel_t      evIp;
   logic        take;
   logic        takeNmi;
   logic        goShut;
   logic        goRestart;
   logic [7:0]  next_vector;
   logic [31:0] next_err;
   logic        next_hasErr;
   ipsel_t      next_ip;
   logic [31:0] lastErr;

   // ----------------------------------------
   // check decode
   // ----------------------------------------
   fault_check_decode checks (
      .chkValid  (chkValid),
      .chkSource (chkSource),
      .chkCond   (chkCond),
      .chkSeg    (chkSeg),
      .longMode  (longMode),
      .tssSel    (tssSel),
      .ldtSel    (ldtSel),
      .csSel     (csSel),
      .dataSel   (dataSel),
      .gateSel   (gateSel),
      .ssSel     (ssSel),
      .hit       (chkHit),
      .vector    (chkVector),
      .errCode   (chkErr),
      .ipSel     (chkIp)
   );

   // ----------------------------------------
   // pin synchronisers
   // ----------------------------------------
   always_ff @(posedge clock) begin
      if (srst) begin
         nmiMeta  <= 1'b0;
         nmiSync  <= 1'b0;
         nmiLast  <= 1'b0;
         initMeta <= 1'b0;
         initSync <= 1'b0;
         initLast <= 1'b0;
      end else begin
         nmiMeta  <= nmiPin;
         nmiSync  <= nmiMeta;
         nmiLast  <= nmiSync;
         initMeta <= initPin;
         initSync <= initMeta;
         initLast <= initSync;
      end
   end

   assign nmiEdge  = nmiSync & ~nmiLast;
   assign initEdge = initSync & ~initLast;

   // ----------------------------------------
   // event merge
   // ----------------------------------------
   always_comb begin
      evValid  = chkHit | excValid;
      evVector = excVector;
      evErr    = excErrCode;
      evHasErr = excHasErr;
      evIp     = IP_FAULT;
      if (chkHit) begin
         evVector = chkVector;
         evErr    = chkErr;
         evHasErr = 1'b1;
         evIp     = chkIp;
      end else if (excVector == `VEC_CSO) begin
         evVector = `VEC_GP;
         evErr    = `ERR_ZERO;
         evHasErr = 1'b1;
      end
   end

   // ----------------------------------------
   // escalation
   // ----------------------------------------
   always_comb begin
      next_state  = state;
      take        = 1'b0;
      takeNmi     = 1'b0;
      goShut      = 1'b0;
      goRestart   = 1'b0;
      next_vector = evVector;
      next_err    = evErr;
      next_hasErr = evHasErr;
      next_ip     = evIp;
      case (state)
         ST_IDLE: begin
            if (evValid) begin
               take = 1'b1;
            end else if (nmiPending && !inNmi) begin
               takeNmi = 1'b1;
            end
         end
         ST_DELIVER: begin
            if (dlvClass == CL_DOUBLE && (evValid || (nmiPending && !inNmi))) begin
               goShut = 1'b1;
            end else if (evValid) begin
               take = 1'b1;
               if ((dlvClass == CL_CONTRIB && classOf(evVector) == CL_CONTRIB) ||
                   (dlvClass == CL_PAGE && classOf(evVector) != CL_BENIGN)) begin
                  next_vector = `VEC_DF;
                  next_err    = `ERR_ZERO;
                  next_hasErr = 1'b1;
                  next_ip     = IP_UNDEF;
               end
            end else if (handlerStart) begin
               next_state = ST_IDLE;
            end
         end
         ST_SHUT: begin
            if (initEdge) begin
               goRestart = 1'b1;
            end else if (nmiPending && !nmiLocked) begin
               takeNmi = 1'b1;
            end
         end
         default: next_state = ST_IDLE;
      endcase
      if (takeNmi) begin
         next_vector = `VEC_NMI;
         next_err    = `ERR_ZERO;
         next_hasErr = 1'b0;
         next_ip     = IP_FAULT;
      end
      if (take || takeNmi) begin
         next_state = ST_DELIVER;
      end
      if (goShut) begin
         next_state = ST_SHUT;
      end
      if (goRestart) begin
         next_state = ST_IDLE;
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         state    <= ST_IDLE;
         dlvClass <= CL_BENIGN;
      end else begin
         state <= next_state;
         if (take || takeNmi) begin
            dlvClass <= classOf(next_vector);
         end else if (next_state == ST_IDLE) begin
            dlvClass <= CL_BENIGN;
         end
      end
   end

   // ----------------------------------------
   // nmi tracking
   // ----------------------------------------
   always_ff @(posedge clock) begin
      if (srst) begin
         nmiPending <= 1'b0;
         inNmi      <= 1'b0;
         nmiLocked  <= 1'b0;
      end else begin
         if (nmiEdge) begin
            nmiPending <= 1'b1;
         end else if (takeNmi || goShut) begin
            nmiPending <= 1'b0;
         end
         if (takeNmi) begin
            inNmi <= 1'b1;
         end else if (iretDone || goRestart) begin
            inNmi <= 1'b0;
         end
         if (goShut) begin
            nmiLocked <= inNmi;
         end else if (goRestart) begin
            nmiLocked <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // dispatch outputs
   // ----------------------------------------
   always_ff @(posedge clock) begin
      if (srst) begin
         dispatchValid   <= 1'b0;
         dispatchVector  <= 8'h00;
         dispatchErrCode <= `ERR_ZERO;
         dispatchHasErr  <= 1'b0;
         dispatchIpSel   <= IP_FAULT;
         shutdown        <= 1'b0;
         restart         <= 1'b0;
         lastErr         <= `ERR_ZERO;
      end else begin
         dispatchValid <= take || takeNmi;
         restart       <= goRestart;
         shutdown      <= (next_state == ST_SHUT);
         if (take || takeNmi) begin
            dispatchVector  <= next_vector;
            dispatchErrCode <= next_err;
            dispatchHasErr  <= next_hasErr;
            dispatchIpSel   <= next_ip;
            lastErr         <= next_err;
         end
      end
   end

   // ----------------------------------------
   // register port
   // ----------------------------------------
   always_ff @(posedge clock) begin
      if (srst) begin
         longMode <= `CTRL_LONG_RST;
      end else if (regWrite && regAddr == `OFS_CTRL) begin
         longMode <= regWdata[`CTRL_LONG_BIT];
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         regRdata <= 32'h0000_0000;
      end else if (regRead) begin
         regRdata <= 32'h0000_0000;
         case (regAddr)
            `OFS_CTRL: regRdata[`CTRL_LONG_BIT] <= longMode;
            `OFS_STATUS: begin
               regRdata[`STAT_STATE_LSB +: 3] <= state;
               regRdata[`STAT_CLASS_LSB +: 2] <= dlvClass;
               regRdata[`STAT_INNMI_BIT]      <= inNmi;
               regRdata[`STAT_LOCK_BIT]       <= nmiLocked;
            end
            `OFS_LASTVEC: regRdata[7:0] <= dispatchVector;
            `OFS_LASTERR: regRdata <= lastErr;
            default: regRdata <= 32'h0000_0000;
         endcase
      end else begin
         regRdata <= 32'h0000_0000;
      end
   end

   // ----------------------------------------
   // assertions
   // ----------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (srst);

   sequence s_contrib_nested;
      state == ST_DELIVER && dlvClass == CL_CONTRIB && evValid && classOf(evVector) == CL_CONTRIB;
   endsequence

   sequence s_page_nested;
      state == ST_DELIVER && dlvClass == CL_PAGE && evValid && classOf(evVector) != CL_BENIGN;
   endsequence

   sequence s_df_hit;
      state == ST_DELIVER && dlvClass == CL_DOUBLE && evValid;
   endsequence

   sequence s_handler_go;
      state == ST_DELIVER && handlerStart && !evValid && dlvClass != CL_DOUBLE;
   endsequence

   a_contrib_escalate: assert property (s_contrib_nested |=> dispatchValid && dispatchVector == `VEC_DF)
      else $error("nested contributory fault not escalated");
   a_page_escalate: assert property (s_page_nested |=> dispatchValid && dispatchVector == `VEC_DF)
      else $error("fault during page fault not escalated");
   a_benign_pass: assert property (state == ST_DELIVER && dlvClass == CL_BENIGN && evValid
      |=> dispatchValid && dispatchVector == $past(evVector))
      else $error("benign first event caused escalation");
   a_class_record: assert property (state == ST_IDLE && excValid && !chkHit && excVector == `VEC_DE
      |=> dlvClass == CL_CONTRIB ##1 1'b1)
      else $error("divide fault not held as contributory");
   a_shut_entry: assert property (s_df_hit |=> shutdown && !dispatchValid)
      else $error("event during double fault delivery did not shut down");
   a_shut_hold: assert property (shutdown && !initEdge && !(nmiPending && !nmiLocked)
      |=> shutdown)
      else $error("shutdown left without a restart source");
   a_nmi_locked: assert property (state == ST_SHUT && nmiLocked && !initEdge |=> !dispatchValid)
      else $error("nmi released a locked shutdown");
   a_df_code: assert property (dispatchValid && dispatchVector == `VEC_DF
      |-> dispatchErrCode == `ERR_ZERO && dispatchHasErr && dispatchIpSel == IP_UNDEF)
      else $error("double fault dispatched with wrong code or pointer");
   a_no_vec9: assert property (dispatchValid |-> dispatchVector != `VEC_CSO)
      else $error("reserved vector raised");
   a_ss_absent: assert property (state == ST_IDLE && chkHit && chkCond == C_ABSENT && chkSeg == SEG_STACK
      |=> dispatchVector == `VEC_SS && dispatchErrCode == {16'h0000, $past(ssSel) & `SEL_INDEX_MASK})
      else $error("absent stack descriptor not reported as stack fault");
   a_task_long: assert property (longMode && (chkSource == SRC_TASK_PRE || chkSource == SRC_TASK_POST)
      |-> !chkHit)
      else $error("task switch fault in long mode");
   a_deliver_clear: assert property (s_handler_go |=> state == ST_IDLE && dlvClass == CL_BENIGN)
      else $error("delivery state not cleared at handler start");
   a_restart_init: assert property (state == ST_SHUT && initEdge |=> restart && !shutdown ##1 !restart)
      else $error("warm restart did not leave shutdown");

endmodule

/* File: rtl/fault_escalation_regs.svh */
// constants for the fault escalation unit
`ifndef FAULT_ESCALATION_REGS_SVH
`define FAULT_ESCALATION_REGS_SVH

// ----------------------------------------
// vectors
// ----------------------------------------
`define VEC_DE         8'h00
`define VEC_NMI        8'h02
`define VEC_DF         8'h08
`define VEC_CSO        8'h09
`define VEC_TS         8'h0A
`define VEC_NP         8'h0B
`define VEC_SS         8'h0C
`define VEC_GP         8'h0D
`define VEC_PF         8'h0E

// ----------------------------------------
// error codes
// ----------------------------------------
`define ERR_ZERO       32'h0000_0000
`define SEL_INDEX_MASK 16'hFFFC

// ----------------------------------------
// register offsets
// ----------------------------------------
`define OFS_CTRL       8'h00
`define OFS_STATUS     8'h04
`define OFS_LASTVEC    8'h08
`define OFS_LASTERR    8'h0C

// ----------------------------------------
// fields and reset values
// ----------------------------------------
`define CTRL_LONG_BIT  0
`define CTRL_RESET     32'h0000_0000
`define CTRL_LONG_RST  1'b0
`define STAT_STATE_LSB 0
`define STAT_CLASS_LSB 3
`define STAT_INNMI_BIT 5
`define STAT_LOCK_BIT  6

`endif

/* File: rtl/fault_escalation_pkg.sv */
// types for the fault escalation unit
package fault_escalation_pkg;

   typedef enum logic [2:0] {
      ST_IDLE    = 3'h1,
      ST_DELIVER = 3'h2,
      ST_SHUT    = 3'h4
   } state_t;

   typedef enum logic [1:0] {
      CL_BENIGN  = 2'h0,
      CL_CONTRIB = 2'h1,
      CL_PAGE    = 2'h2,
      CL_DOUBLE  = 2'h3
   } class_t;

   typedef enum logic [1:0] {
      SRC_LOAD      = 2'h0,
      SRC_TASK_PRE  = 2'h1,
      SRC_TASK_POST = 2'h2,
      SRC_GATE      = 2'h3
   } src_t;

   typedef enum logic [3:0] {
      C_TSS_LIMIT   = 4'h0,
      C_LDT_NOT_GDT = 4'h1,
      C_LDT_OUT     = 4'h2,
      C_LDT_TYPE    = 4'h3,
      C_LDT_ABSENT  = 4'h4,
      C_CS_RANGE    = 4'h5,
      C_CS_CONF     = 4'h6,
      C_CS_NONCONF  = 4'h7,
      C_CS_EXEC     = 4'h8,
      C_DS_RANGE    = 4'h9,
      C_DS_READ     = 4'hA,
      C_SS_RANGE    = 4'hB,
      C_SS_DPL      = 4'hC,
      C_SS_RPL      = 4'hD,
      C_SS_WRITE    = 4'hE,
      C_ABSENT      = 4'hF
   } cond_t;

   typedef enum logic [2:0] {
      SEG_DATA  = 3'h0,
      SEG_CODE  = 3'h1,
      SEG_STACK = 3'h2,
      SEG_GATE  = 3'h3,
      SEG_TSS   = 3'h4,
      SEG_LDT   = 3'h5
   } seg_t;

   typedef enum logic [1:0] {
      IP_FAULT    = 2'h0,
      IP_NEW_TASK = 2'h1,
      IP_TRANSFER = 2'h2,
      IP_UNDEF    = 2'h3
   } ipsel_t;

endpackage

/* File: rtl/fault_check_decode.sv */
// selector and descriptor check decode into a fault
`timescale 1ns/10ps
`include "fault_escalation_regs.svh"
module fault_check_decode
   import fault_escalation_pkg::*;
(
   input  wire logic        chkValid,
   input  wire src_t        chkSource,
   input  wire cond_t       chkCond,
   input  wire seg_t        chkSeg,
   input  wire logic        longMode,
   input  wire logic [15:0] tssSel,
   input  wire logic [15:0] ldtSel,
   input  wire logic [15:0] csSel,
   input  wire logic [15:0] dataSel,
   input  wire logic [15:0] gateSel,
   input  wire logic [15:0] ssSel,
   output logic             hit,
   output logic [7:0]       vector,
   output logic [31:0]      errCode,
   output ipsel_t           ipSel
);

   function automatic logic [31:0] selIndex(input logic [15:0] sel);
      selIndex = {16'h0000, sel & `SEL_INDEX_MASK};
   endfunction

   logic isTask;

   always_comb begin
      isTask  = (chkSource == SRC_TASK_PRE) || (chkSource == SRC_TASK_POST);
      hit     = chkValid;
      vector  = `VEC_TS;
      errCode = `ERR_ZERO;
      case (chkSource)
         SRC_TASK_PRE:  ipSel = IP_FAULT;
         SRC_TASK_POST: ipSel = IP_NEW_TASK;
         SRC_GATE:      ipSel = IP_TRANSFER;
         default:       ipSel = IP_FAULT;
      endcase
      case (chkCond)
         C_TSS_LIMIT: errCode = selIndex(tssSel);
         C_LDT_NOT_GDT, C_LDT_OUT, C_LDT_TYPE, C_LDT_ABSENT:
            errCode = selIndex(ldtSel);
         C_CS_RANGE, C_CS_CONF, C_CS_NONCONF, C_CS_EXEC:
            errCode = selIndex(csSel);
         C_DS_RANGE, C_DS_READ: errCode = selIndex(dataSel);
         C_SS_RANGE, C_SS_DPL, C_SS_RPL, C_SS_WRITE:
            errCode = selIndex(ssSel);
         C_ABSENT: begin
            vector = `VEC_NP;
            case (chkSeg)
               SEG_CODE:  errCode = selIndex(csSel);
               SEG_GATE:  errCode = selIndex(gateSel);
               SEG_TSS:   errCode = selIndex(tssSel);
               SEG_LDT:   errCode = selIndex(ldtSel);
               SEG_STACK: begin
                  vector  = `VEC_SS;
                  errCode = selIndex(ssSel);
               end
               default:   errCode = selIndex(dataSel);
            endcase
         end
         default: hit = 1'b0;
      endcase
      // long mode has no hardware task switch
      if (longMode && isTask) begin
         hit = 1'b0;
      end
      if (chkCond != C_ABSENT && chkSource == SRC_LOAD) begin
         hit = 1'b0;
      end
   end

endmodule

/* File: tb/fault_source_model.sv */
// pipeline fault reporter and pin driver model
`timescale 1ns/10ps
module fault_source_model
   import fault_escalation_pkg::*;
(
   input  wire logic   clock,
   output logic        excValid,
   output logic [7:0]  excVector,
   output logic [31:0] excErrCode,
   output logic        excHasErr,
   output logic        chkValid,
   output src_t        chkSource,
   output cond_t       chkCond,
   output seg_t        chkSeg,
   output logic        nmiPin,
   output logic        initPin,
   output logic        handlerStart,
   output logic        iretDone
);
   initial begin
      {excValid, excVector, excErrCode, excHasErr, chkValid} = '0;
      {nmiPin, initPin, handlerStart, iretDone} = '0;
      chkSource = SRC_LOAD;
      chkCond = C_TSS_LIMIT;
      chkSeg = SEG_DATA;
   end
   // one-cycle exception report
   task automatic exc(input logic [7:0] v, input logic [31:0] e);
      excValid <= 1'b1;
      excVector <= v;
      excErrCode <= e;
      excHasErr <= |e;
      chkValid <= 1'b0;
      @(posedge clock);
   endtask
   // one-cycle check failure report
   task automatic chk(input src_t s, input cond_t c, input seg_t g);
      chkValid <= 1'b1;
      chkSource <= s;
      chkCond <= c;
      chkSeg <= g;
      excValid <= 1'b0;
      @(posedge clock);
   endtask
   task automatic idle(input logic hs);
      excValid <= 1'b0;
      chkValid <= 1'b0;
      handlerStart <= hs;
      @(posedge clock);
   endtask
   // pin pulse, long enough for the synchroniser
   task automatic pin(input logic isNmi);
      nmiPin <= isNmi;
      initPin <= !isNmi;
      repeat (4) @(posedge clock);
      nmiPin <= 1'b0;
      initPin <= 1'b0;
      @(posedge clock);
   endtask
   task automatic iret;
      iretDone <= 1'b1;
      @(posedge clock);
      iretDone <= 1'b0;
   endtask
endmodule

/* File: tb/test_fault_escalation.sv */
// self-checking bench for the fault escalation unit
`timescale 1ns/10ps
`include "fault_escalation_regs.svh"
module test_fault_escalation;
   import fault_escalation_pkg::*;
   typedef struct packed {
      logic        isChk;
      logic [7:0]  vin;
      src_t        src;
      cond_t       cond;
      seg_t        seg;
      logic [7:0]  vec;
      logic [15:0] err;
      ipsel_t      ip;
   } row_t;
   localparam row_t rows [20] = '{
      '{1, 0, SRC_TASK_PRE, C_TSS_LIMIT, SEG_DATA, 8'h0A, 16'h0010, IP_FAULT},
      '{1, 0, SRC_GATE, C_TSS_LIMIT, SEG_DATA, 8'h0A, 16'h0010, IP_TRANSFER},
      '{1, 0, SRC_TASK_POST, C_LDT_NOT_GDT, SEG_DATA, 8'h0A, 16'h0024, IP_NEW_TASK},
      '{1, 0, SRC_TASK_POST, C_LDT_ABSENT, SEG_DATA, 8'h0A, 16'h0024, IP_NEW_TASK},
      '{1, 0, SRC_TASK_POST, C_CS_CONF, SEG_DATA, 8'h0A, 16'h0038, IP_NEW_TASK},
      '{1, 0, SRC_TASK_POST, C_CS_EXEC, SEG_DATA, 8'h0A, 16'h0038, IP_NEW_TASK},
      '{1, 0, SRC_TASK_POST, C_DS_READ, SEG_DATA, 8'h0A, 16'h0040, IP_NEW_TASK},
      '{1, 0, SRC_GATE, C_SS_RPL, SEG_DATA, 8'h0A, 16'h0068, IP_TRANSFER},
      '{1, 0, SRC_TASK_POST, C_SS_WRITE, SEG_DATA, 8'h0A, 16'h0068, IP_NEW_TASK},
      '{1, 0, SRC_LOAD, C_ABSENT, SEG_DATA, 8'h0B, 16'h0040, IP_FAULT},
      '{1, 0, SRC_LOAD, C_ABSENT, SEG_STACK, 8'h0C, 16'h0068, IP_FAULT},
      '{1, 0, SRC_LOAD, C_ABSENT, SEG_GATE, 8'h0B, 16'h0054, IP_FAULT},
      '{1, 0, SRC_TASK_POST, C_ABSENT, SEG_CODE, 8'h0B, 16'h0038, IP_NEW_TASK},
      '{1, 0, SRC_LOAD, C_ABSENT, SEG_LDT, 8'h0B, 16'h0024, IP_FAULT},
      '{1, 0, SRC_LOAD, C_ABSENT, SEG_TSS, 8'h0B, 16'h0010, IP_FAULT},
      '{1, 0, SRC_TASK_POST, C_LDT_OUT, SEG_DATA, 8'h0A, 16'h0024, IP_NEW_TASK},
      '{1, 0, SRC_TASK_PRE, C_CS_NONCONF, SEG_DATA, 8'h0A, 16'h0038, IP_FAULT},
      '{1, 0, SRC_TASK_POST, C_DS_RANGE, SEG_DATA, 8'h0A, 16'h0040, IP_NEW_TASK},
      '{1, 0, SRC_GATE, C_SS_RANGE, SEG_DATA, 8'h0A, 16'h0068, IP_TRANSFER},
      '{0, 8'h09, SRC_LOAD, C_ABSENT, SEG_DATA, 8'h0D, 16'h0000, IP_FAULT}};
   logic        clock, srst, regWrite, regRead, excValid, excHasErr, chkValid, nmiPin, initPin;
   logic        handlerStart, iretDone, dispatchValid, dispatchHasErr, shutdown, restart;
   logic [7:0]  regAddr, excVector, dispatchVector;
   logic [31:0] regWdata, regRdata, excErrCode, dispatchErrCode, r;
   logic [15:0] tssSel, ldtSel, csSel, dataSel, gateSel, ssSel, k;
   src_t        chkSource;
   cond_t       chkCond;
   seg_t        chkSeg;
   ipsel_t      dispatchIpSel;
   logic [42:0] dq[$];
   logic [42:0] d;
   int          fails, samplesChecked, restarts;

   fault_escalation i_dut (.clock, .srst, .regAddr, .regWdata, .regWrite, .regRead, .regRdata,
      .excValid, .excVector, .excErrCode, .excHasErr, .chkValid, .chkSource, .chkCond, .chkSeg,
      .tssSel, .ldtSel, .csSel, .dataSel, .gateSel, .ssSel, .nmiPin, .initPin, .handlerStart,
      .iretDone, .dispatchValid, .dispatchVector, .dispatchErrCode, .dispatchHasErr,
      .dispatchIpSel, .shutdown, .restart);
   fault_source_model i_src (.clock, .excValid, .excVector, .excErrCode, .excHasErr, .chkValid,
      .chkSource, .chkCond, .chkSeg, .nmiPin, .initPin, .handlerStart, .iretDone);

   // --------------------------------
   // monitor and helpers
   // --------------------------------
   always @(negedge clock) begin
      if (dispatchValid === 1'b1) begin
         dq.push_back({dispatchVector, dispatchErrCode, dispatchHasErr, dispatchIpSel});
      end
      if (restart === 1'b1) begin
         restarts++;
      end
   end
   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      samplesChecked++;
      if (seen !== exp) begin
         fails++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic pop;
      check(dq.size() != 0, 1);
      d = (dq.size() != 0) ? dq.pop_front() : 'x;
   endtask
   task automatic settle;
      repeat (4) @(posedge clock);
   endtask
   task automatic fin;
      i_src.idle(1'b1);
      i_src.idle(1'b0);
      settle();
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      regWrite <= 1'b1;
      regAddr <= a;
      regWdata <= v;
      @(posedge clock);
      regWrite <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      regRead <= 1'b1;
      regAddr <= a;
      @(posedge clock);
      regRead <= 1'b0;
      @(negedge clock);
      r = regRdata;
      @(posedge clock);
   endtask
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", samplesChecked, fails);
      if (fails == 0 && samplesChecked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // --------------------------------
   // clock, watchdog, tests
   // --------------------------------
   initial begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end
   initial begin
      #20000;
      fails++;
      report_and_stop();
   end
   initial begin
      {srst, regWrite, regRead, regAddr, regWdata} = {1'b1, 42'h0};
      {tssSel, ldtSel, csSel} = {16'h0013, 16'h0027, 16'h003B};
      {dataSel, gateSel, ssSel} = {16'h0042, 16'h0055, 16'h006B};
      repeat (16) @(posedge clock);
      srst <= 1'b0;
      @(negedge clock);
      check({shutdown, dispatchValid, restart}, 0);
      @(posedge clock);
      rd(`OFS_CTRL);
      check(r, 0);
      rd(`OFS_STATUS);
      check(r, 1);
      rd(8'h10);
      check(r, 0);
      $display("reset test done");
      foreach (rows[i]) begin
         k = {8'(i), 8'h00};
         {tssSel, ldtSel, csSel} <= {16'h0013, 16'h0027, 16'h003B} ^ {3{k}};
         {dataSel, gateSel, ssSel} <= {16'h0042, 16'h0055, 16'h006B} ^ {3{k}};
         if (rows[i].isChk) begin
            i_src.chk(rows[i].src, rows[i].cond, rows[i].seg);
         end else begin
            i_src.exc(rows[i].vin, 32'h0000_0077);
         end
         fin();
         pop();
         check(d, {rows[i].vec, 16'h0, rows[i].err ^ (rows[i].isChk ? k : 16'h0000), 1'b1, rows[i].ip});
         check(d[1:0], rows[i].ip);
      end
      check(dq.size(), 0);
      $display("table test done");
      i_src.exc(8'h00, 0);
      i_src.exc(8'h0D, 0);
      i_src.exc(8'h0E, 0);
      i_src.exc(8'h0D, 0);
      i_src.idle(1'b0);
      settle();
      pop();
      check(d[42:35], 8'h00);
      pop();
      check(d, {8'h08, 32'h0, 1'b1, IP_UNDEF});
      check({dq.size(), shutdown}, 1);
      i_src.pin(1'b1);
      settle();
      pop();
      check({d[42:35], shutdown}, {8'h02, 1'b0});
      fin();
      i_src.exc(8'h0E, 32'h0000_0077);
      i_src.exc(8'h0E, 32'h0000_0077);
      i_src.exc(8'h00, 0);
      i_src.idle(1'b0);
      settle();
      pop();
      check(d[42:35], 8'h0E);
      pop();
      check(d[42:35], 8'h08);
      i_src.pin(1'b1);
      settle();
      check({dq.size(), shutdown}, 1);
      i_src.pin(1'b0);
      settle();
      check({restarts, shutdown}, {32'h1, 1'b0});
      dq.delete();
      fin();
      i_src.iret();
      $display("shutdown test done");
      i_src.exc(8'h03, 0);
      i_src.exc(8'h0D, 0);
      i_src.idle(1'b0);
      settle();
      pop();
      check(d[42:35], 8'h03);
      pop();
      check({d[42:35], dq.size()}, {8'h0D, 32'h0});
      fin();
      rd(`OFS_STATUS);
      check(r[6:0], 7'h01);
      $display("benign test done");
      wr(`OFS_CTRL, 32'h0000_0001);
      rd(`OFS_CTRL);
      check(r, 1);
      ssSel <= 16'h7FFF;
      i_src.chk(SRC_TASK_POST, C_CS_CONF, SEG_DATA);
      i_src.chk(SRC_TASK_POST, C_ABSENT, SEG_CODE);
      i_src.idle(1'b0);
      settle();
      check(dq.size(), 0);
      i_src.chk(SRC_GATE, C_SS_DPL, SEG_DATA);
      i_src.idle(1'b0);
      settle();
      pop();
      check(d, {8'h0A, 32'h0000_7FFC, 1'b1, IP_TRANSFER});
      fin();
      $display("long mode test done");
      report_and_stop();
   end
endmodule
